// ---- common/dms_pkg.sv ----
// shared constants, enums and carrier structs of the arithmetic slice
// assumes one clock domain; included by every design file of the slice
package dms_pkg;

    // ========================================================
    // datapath widths
    localparam int DMS_A_W = 27;        // multiplicand width
    localparam int DMS_B_W = 18;        // multiplier width
    localparam int DMS_PRE_W = 28;      // pre-adder sum width
    localparam int DMS_PROD_W = 46;     // full product width
    localparam int DMS_ACC_W = 48;      // accumulator width
    localparam int DMS_LANE_W = 12;     // narrowest simd lane
    localparam int DMS_LANES = 4;       // lanes of 12 bits
    localparam int DMS_XGRP = 8;        // 12-bit groups in 96 bits
    localparam int DMS_LAT = 3;         // input to result cycles

    // ========================================================
    // register port
    localparam int DMS_AW = 6;
    localparam int DMS_DW = 32;
    localparam int DMS_HI_W = 16;       // upper part of a 48-bit reg
    localparam logic [5:0] DMS_CTRL_OFS = 6'h00;
    localparam logic [5:0] DMS_PATLO_OFS = 6'h04;
    localparam logic [5:0] DMS_PATHI_OFS = 6'h08;
    localparam logic [5:0] DMS_MSKLO_OFS = 6'h0C;
    localparam logic [5:0] DMS_MSKHI_OFS = 6'h10;
    localparam logic [5:0] DMS_STAT_OFS = 6'h14;
    localparam logic [5:0] DMS_ACCLO_OFS = 6'h18;
    localparam logic [5:0] DMS_ACCHI_OFS = 6'h1C;
    localparam logic [1:0] DMS_CTRL_RST = 2'h3;   // xor over 96
    localparam logic [47:0] DMS_PAT_RST = 48'h0;
    localparam logic [47:0] DMS_MSK_RST = 48'h0;

    // ========================================================
    // operation codes
    typedef enum logic [2:0] {
        OP_ADD, OP_SUB, OP_LOGIC, OP_CNT_UP, OP_CNT_DN
    } dms_alu_e;
    typedef enum logic [1:0] {Z_ZERO, Z_C, Z_ACC} dms_zsel_e;
    typedef enum logic [1:0] {S_ONE48, S_TWO24, S_FOUR12} dms_simd_e;
    typedef enum logic [1:0] {XW12, XW24, XW48, XW96} dms_xw_e;
    typedef enum logic [3:0] {
        LF_AND, LF_OR, LF_XOR, LF_NAND, LF_NOR, LF_XNOR,
        LF_AND_NOTV, LF_OR_NOTV, LF_NOTU_AND, LF_NOTU_OR
    } dms_lfn_e;

    // ========================================================
    // carriers
    typedef struct packed {
        logic signed [26:0] a;          // multiplicand / pre-add term
        logic signed [26:0] d;          // second pre-add term
        logic signed [17:0] b;          // multiplier
        logic [47:0] c;                 // z-side operand
        logic [47:0] ab;                // bypass word
    } dms_opnd_s;

    typedef struct packed {
        logic use_mult;                 // 0: ab bypasses multiplier
        logic preadd_en;
        logic preadd_sub;               // d - a instead of d + a
        dms_alu_e op;
        dms_zsel_e zsel;
        dms_simd_e simd;
        dms_lfn_e lfn;
    } dms_ctl_s;

endpackage

// ---- rtl/dms_simd_add.sv ----
// lane-splittable 48-bit adder/subtractor of the arithmetic slice
// assumes purely combinational use inside the slice pipeline
`timescale 1ns/10ps

module dms_simd_add (
    input wire logic [47:0] x,
    input wire logic [47:0] y,
    input wire logic sub,
    input wire dms_pkg::dms_simd_e mode,
    output logic [47:0] sum,
    output logic [3:0] cout
);

    // ========================================================
    // lane chain
    // carry into each lane; lane 0 always starts with sub
    logic [dms_pkg::DMS_LANES:0] cin;
    // lane boundary broken in current split
    logic [dms_pkg::DMS_LANES-1:0] brk;

    assign cin[0] = sub;

    genvar gi;
    generate
        for (gi = 0; gi < dms_pkg::DMS_LANES; gi++) begin : g_lane
            localparam int LO = gi * dms_pkg::DMS_LANE_W;
            localparam int HI = LO + dms_pkg::DMS_LANE_W - 1;
            logic [dms_pkg::DMS_LANE_W:0] ls;
            logic [dms_pkg::DMS_LANE_W-1:0] yl;
            // odd lanes split only in quad mode, lane 2 in both
            if (gi == 0) begin : g_b0
                assign brk[gi] = 1'b1;
            end else if (gi == 2) begin : g_b2
                assign brk[gi] = (mode != dms_pkg::S_ONE48);
            end else begin : g_bx
                assign brk[gi] = (mode == dms_pkg::S_FOUR12);
            end
            // subtract as x + ~y + 1, restarted at each broken lane boundary
            assign yl = sub ? ~y[HI:LO] : y[HI:LO];
            assign ls = {1'b0, x[HI:LO]} + {1'b0, yl}
                + {{dms_pkg::DMS_LANE_W{1'b0}},
                   (brk[gi] ? sub : cin[gi])};
            assign sum[HI:LO] = ls[dms_pkg::DMS_LANE_W-1:0];
            assign cin[gi+1] = ls[dms_pkg::DMS_LANE_W];
            assign cout[gi] = ls[dms_pkg::DMS_LANE_W];
        end
    endgenerate

endmodule // dms_simd_add

// ---- rtl/dms_slice.sv ----
// multiply-accumulate slice with pre-adder, simd alu, logic unit,
// wide xor and pattern detector, plus a small register port
// assumes operands and controls come from fabric on core_clk
//
// Functional notes
// RULE1: signed 27 by 18 full product
// RULE2: 48-bit running accumulator
// RULE3: multiplier bypass feeds two 48-bit words
// RULE4: simd lanes 2x24 or 4x12, no carry
// RULE5: ten selectable bitwise logic functions
// RULE6: pre-adder combines operands before multiply
// RULE7: 96-bit xor, granularity 12/24/48/96
// RULE8: 48-bit pattern detector for rounding
// RULE9: logic unit plus detector spans 96 bits
// RULE10: accumulator counts up or down
// RULE11: one clock; sync clear zeroes pipeline
// RULE12: fabric keeps controls stable, honours latency
//
// The register offsets and the address-and-strobe port were decided locally.
`timescale 1ns/10ps

module dms_slice (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic sync_clr,
    input wire logic in_valid,
    input wire dms_pkg::dms_opnd_s opnd,
    input wire dms_pkg::dms_ctl_s ctl,
    input wire logic [5:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    output logic [47:0] res,
    output logic res_valid,
    output logic [3:0] carry,
    output logic [7:0] xor_out,
    output logic pd_valid,
    output logic pat_match,
    output logic pat_match_b
);

    // ========================================================
    // software registers
    dms_pkg::dms_xw_e xw_r;             // xor granularity
    logic [47:0] pat_r;                 // detector pattern
    logic [47:0] msk_r;                 // 1 = bit ignored
    logic [31:0] rdata_r;
    logic [31:0] rdata_nxt;

    // register writes; unmapped offsets are dropped
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            xw_r <= dms_pkg::dms_xw_e'(dms_pkg::DMS_CTRL_RST);
            pat_r <= dms_pkg::DMS_PAT_RST;
            msk_r <= dms_pkg::DMS_MSK_RST;
        end else if (reg_wr) begin
            case (reg_addr)
                dms_pkg::DMS_CTRL_OFS: begin
                    xw_r <= dms_pkg::dms_xw_e'(reg_wdata[1:0]);
                end
                dms_pkg::DMS_PATLO_OFS: begin
                    pat_r[31:0] <= reg_wdata;
                end
                dms_pkg::DMS_PATHI_OFS: begin
                    pat_r[47:32] <= reg_wdata[15:0];
                end
                dms_pkg::DMS_MSKLO_OFS: begin
                    msk_r[31:0] <= reg_wdata;
                end
                dms_pkg::DMS_MSKHI_OFS: begin
                    msk_r[47:32] <= reg_wdata[15:0];
                end
                default: begin
                    // read-only or unmapped
                end
            endcase
        end
    end

    // read mux; unmapped reads give zero
    always_comb begin
        case (reg_addr)
            dms_pkg::DMS_CTRL_OFS: rdata_nxt = {30'h0, xw_r};
            dms_pkg::DMS_PATLO_OFS: rdata_nxt = pat_r[31:0];
            dms_pkg::DMS_PATHI_OFS: rdata_nxt = {16'h0, pat_r[47:32]};
            dms_pkg::DMS_MSKLO_OFS: rdata_nxt = msk_r[31:0];
            dms_pkg::DMS_MSKHI_OFS: rdata_nxt = {16'h0, msk_r[47:32]};
            dms_pkg::DMS_STAT_OFS: begin
                rdata_nxt = {28'h0, pd_valid, res_valid,
                             pat_match_b, pat_match};
            end
            dms_pkg::DMS_ACCLO_OFS: rdata_nxt = res[31:0];
            dms_pkg::DMS_ACCHI_OFS: rdata_nxt = {16'h0, res[47:32]};
            default: rdata_nxt = 32'h0;
        endcase
    end

    // read data stands only in the cycle after the strobe
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            rdata_r <= 32'h0;
        end else begin
            rdata_r <= reg_rd ? rdata_nxt : 32'h0;
        end
    end
    assign reg_rdata = rdata_r;

    // ========================================================
    // stage 1: operand capture and pre-adder
    logic v1_r;
    logic signed [27:0] pre_r;          // d +/- a, or a alone
    logic signed [27:0] pre_nxt;
    logic signed [17:0] b1_r;
    logic [47:0] ab1_r;
    logic [47:0] c1_r;
    dms_pkg::dms_ctl_s ctl1_r;

    // RULE6 pre-adder
    // one extra bit keeps d +/- a from wrapping
    always_comb begin
        if (!ctl.preadd_en) begin
            pre_nxt = {opnd.a[26], opnd.a};
        end else if (ctl.preadd_sub) begin
            pre_nxt = {opnd.d[26], opnd.d} - {opnd.a[26], opnd.a};
        end else begin
            pre_nxt = {opnd.d[26], opnd.d} + {opnd.a[26], opnd.a};
        end
    end

    // RULE11 stage 1 clear
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            v1_r <= 1'b0;
            pre_r <= 28'sh0;
            b1_r <= 18'sh0;
            ab1_r <= 48'h0;
            c1_r <= 48'h0;
            ctl1_r <= '0;
        end else if (sync_clr) begin
            v1_r <= 1'b0;
            pre_r <= 28'sh0;
            b1_r <= 18'sh0;
            ab1_r <= 48'h0;
            c1_r <= 48'h0;
            ctl1_r <= '0;
        end else begin
            v1_r <= in_valid;
            pre_r <= pre_nxt;
            b1_r <= opnd.b;
            ab1_r <= opnd.ab;
            c1_r <= opnd.c;
            ctl1_r <= ctl;
        end
    end

    // ========================================================
    // stage 2: multiplier or bypass, xor groups
    logic v2_r;
    logic signed [45:0] prod;           // exact 28 x 18 product
    logic [47:0] w_r;                   // x-side word
    logic [47:0] u_r;                   // z-side word
    logic [7:0] grp_r;                  // parity per 12-bit group
    logic [7:0] grp_nxt;
    dms_pkg::dms_ctl_s ctl2_r;
    logic [95:0] xw_in;

    // RULE1 signed product
    assign prod = pre_r * b1_r;

    // RULE7 group parities
    assign xw_in = {c1_r, ab1_r};
    genvar gx;
    generate
        for (gx = 0; gx < dms_pkg::DMS_XGRP; gx++) begin : g_xg
            assign grp_nxt[gx] =
                ^xw_in[gx*dms_pkg::DMS_LANE_W +: dms_pkg::DMS_LANE_W];
        end
    endgenerate

    // RULE3 bypass select
    // RULE11 stage 2 clear
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            v2_r <= 1'b0;
            w_r <= 48'h0;
            u_r <= 48'h0;
            grp_r <= 8'h0;
            ctl2_r <= '0;
        end else if (sync_clr) begin
            v2_r <= 1'b0;
            w_r <= 48'h0;
            u_r <= 48'h0;
            grp_r <= 8'h0;
            ctl2_r <= '0;
        end else begin
            v2_r <= v1_r;
            // sign-extend product to the accumulator width
            w_r <= ctl1_r.use_mult ? {{2{prod[45]}}, prod} : ab1_r;
            u_r <= (ctl1_r.zsel == dms_pkg::Z_C) ? c1_r : 48'h0;
            grp_r <= grp_nxt;
            ctl2_r <= ctl1_r;
        end
    end

    // ========================================================
    // stage 3: alu, logic unit, accumulator
    logic [47:0] res_r;
    logic [47:0] res_nxt;
    logic res_valid_r;
    logic [3:0] carry_r;
    logic [7:0] xor_r;
    logic [7:0] xor_nxt;
    logic [47:0] z_in;                  // alu left operand
    logic [47:0] y_in;                  // alu right operand
    logic [47:0] sum;
    logic [3:0] lane_co;
    logic [47:0] lu;                    // logic unit result
    logic is_cnt;
    logic do_sub;
    dms_pkg::dms_simd_e mode;

    assign is_cnt = (ctl2_r.op == dms_pkg::OP_CNT_UP)
        || (ctl2_r.op == dms_pkg::OP_CNT_DN);
    assign do_sub = (ctl2_r.op == dms_pkg::OP_SUB)
        || (ctl2_r.op == dms_pkg::OP_CNT_DN);

    // RULE10 counter steps by one
    // RULE2 accumulate feedback
    always_comb begin
        if (is_cnt) begin
            z_in = res_r;
            y_in = 48'h1;
        end else if (ctl2_r.zsel == dms_pkg::Z_ACC) begin
            z_in = res_r;
            y_in = w_r;
        end else begin
            z_in = u_r;
            y_in = w_r;
        end
    end

    // RULE4 lane split
    // product and counter are always one 48-bit lane
    assign mode = (is_cnt || ctl2_r.use_mult) ? dms_pkg::S_ONE48
        : ctl2_r.simd;

    dms_simd_add u_add (
        .x(z_in),
        .y(y_in),
        .sub(do_sub),
        .mode(mode),
        .sum(sum),
        .cout(lane_co)
    );

    // RULE5 ten logic functions
    always_comb begin
        case (ctl2_r.lfn)
            dms_pkg::LF_AND: lu = z_in & y_in;
            dms_pkg::LF_OR: lu = z_in | y_in;
            dms_pkg::LF_XOR: lu = z_in ^ y_in;
            dms_pkg::LF_NAND: lu = ~(z_in & y_in);
            dms_pkg::LF_NOR: lu = ~(z_in | y_in);
            dms_pkg::LF_XNOR: lu = ~(z_in ^ y_in);
            dms_pkg::LF_AND_NOTV: lu = z_in & ~y_in;
            dms_pkg::LF_OR_NOTV: lu = z_in | ~y_in;
            dms_pkg::LF_NOTU_AND: lu = ~z_in & y_in;
            dms_pkg::LF_NOTU_OR: lu = ~z_in | y_in;
            default: lu = 48'h0;
        endcase
    end

    assign res_nxt = (ctl2_r.op == dms_pkg::OP_LOGIC) ? lu : sum;

    // RULE7 granularity select
    // unused upper outputs read zero
    always_comb begin
        case (xw_r)
            dms_pkg::XW12: xor_nxt = grp_r;
            dms_pkg::XW24: begin
                xor_nxt = {4'h0, grp_r[7] ^ grp_r[6],
                           grp_r[5] ^ grp_r[4],
                           grp_r[3] ^ grp_r[2],
                           grp_r[1] ^ grp_r[0]};
            end
            dms_pkg::XW48: begin
                xor_nxt = {6'h0, ^grp_r[7:4], ^grp_r[3:0]};
            end
            default: xor_nxt = {7'h0, ^grp_r};
        endcase
    end

    // RULE11 accumulator clear
    // result holds between valid cycles so the total persists
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            res_r <= 48'h0;
            res_valid_r <= 1'b0;
            carry_r <= 4'h0;
            xor_r <= 8'h0;
        end else if (sync_clr) begin
            res_r <= 48'h0;
            res_valid_r <= 1'b0;
            carry_r <= 4'h0;
            xor_r <= 8'h0;
        end else begin
            res_valid_r <= v2_r;
            if (v2_r) begin
                res_r <= res_nxt;
                carry_r <= lane_co;
                xor_r <= xor_nxt;
            end
        end
    end

    assign res = res_r;
    assign res_valid = res_valid_r;
    assign carry = carry_r;
    assign xor_out = xor_r;

    // ========================================================
    // stage 4: pattern detector
    logic pd_valid_r;
    logic pm_r;
    logic pmb_r;

    // RULE8 masked compare
    // RULE9 wide logic via detector
    // and-reducing a logic unit result covers 96 input bits
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            pd_valid_r <= 1'b0;
            pm_r <= 1'b0;
            pmb_r <= 1'b0;
        end else if (sync_clr) begin
            pd_valid_r <= 1'b0;
            pm_r <= 1'b0;
            pmb_r <= 1'b0;
        end else begin
            pd_valid_r <= res_valid_r;
            // bitwise equality; a mask bit of 1 always agrees
            pm_r <= &(~(res_r ^ pat_r) | msk_r);
            pmb_r <= &((res_r ^ pat_r) | msk_r);
        end
    end

    assign pd_valid = pd_valid_r;
    assign pat_match = pm_r;
    assign pat_match_b = pmb_r;

    // ========================================================
    // checks
    default clocking dcb @(posedge core_clk);
    endclocking
    default disable iff (!rst_b);

    // input-side expectations, read only by the checks
    logic signed [44:0] chk_m;
    logic signed [45:0] chk_pm;
    logic chk_mul;
    logic chk_pre;
    logic chk_acc;
    logic chk_simd;
    logic chk_and;
    logic chk_up;
    logic chk_x;

    assign chk_m = opnd.a * opnd.b;
    assign chk_pm = ($signed({opnd.d[26], opnd.d})
        + $signed({opnd.a[26], opnd.a})) * opnd.b;
    assign chk_mul = in_valid && ctl.use_mult && !ctl.preadd_en
        && ctl.zsel == dms_pkg::Z_ZERO && ctl.op == dms_pkg::OP_ADD;
    assign chk_pre = in_valid && ctl.use_mult && ctl.preadd_en
        && !ctl.preadd_sub && ctl.zsel == dms_pkg::Z_ZERO
        && ctl.op == dms_pkg::OP_ADD;
    assign chk_acc = in_valid && !ctl.use_mult
        && ctl.zsel == dms_pkg::Z_ACC && ctl.op == dms_pkg::OP_ADD
        && ctl.simd == dms_pkg::S_ONE48;
    assign chk_simd = in_valid && !ctl.use_mult
        && ctl.zsel == dms_pkg::Z_C && ctl.op == dms_pkg::OP_SUB
        && ctl.simd == dms_pkg::S_FOUR12;
    assign chk_and = in_valid && !ctl.use_mult
        && ctl.zsel == dms_pkg::Z_C && ctl.op == dms_pkg::OP_LOGIC
        && ctl.lfn == dms_pkg::LF_AND;
    assign chk_up = in_valid && ctl.op == dms_pkg::OP_CNT_UP;
    assign chk_x = ^{opnd.c, opnd.ab};

    a_result_latency: assert property ( // RULE11
        in_valid && !sync_clr ##1 !sync_clr[*2] |=> res_valid)
        else $error("result not valid three cycles after input");
    a_mult_product: assert property ( // RULE1
        res_valid && $past(chk_mul, 3)
        |-> res == {{3{$past(chk_m[44], 3)}}, $past(chk_m, 3)})
        else $error("product mismatch");
    a_acc_running: assert property ( // RULE2
        res_valid && $past(chk_acc, 3)
        |-> res == $past(res) + $past(opnd.ab, 3))
        else $error("accumulator did not add bypass word");
    a_simd_lanes: assert property ( // RULE4
        res_valid && $past(chk_simd, 3)
        |-> res[11:0] == $past(opnd.c[11:0] - opnd.ab[11:0], 3)
        && res[47:36] == $past(opnd.c[47:36] - opnd.ab[47:36], 3))
        else $error("simd lane carried across boundary");
    a_logic_and: assert property ( // RULE5
        res_valid && $past(chk_and, 3)
        |-> res == $past(opnd.c & opnd.ab, 3))
        else $error("logic unit and mismatch");
    a_preadd_mult: assert property ( // RULE6
        res_valid && $past(chk_pre, 3)
        |-> res == {{2{$past(chk_pm[45], 3)}}, $past(chk_pm, 3)})
        else $error("pre-added product mismatch");
    a_xor_full: assert property ( // RULE7
        res_valid && $past(xw_r) == dms_pkg::XW96
        |-> xor_out == {7'h0, $past(chk_x, 3)})
        else $error("96-bit xor mismatch");
    a_count_up: assert property ( // RULE10
        res_valid && $past(chk_up, 3) |-> res == $past(res) + 48'h1)
        else $error("counter did not step up");
    a_pattern_hit: assert property ( // RULE8
        pd_valid |-> pat_match
        == &(~($past(res) ^ $past(pat_r)) | $past(msk_r)))
        else $error("pattern detect mismatch");
    a_sync_clear: assert property ( // RULE11
        sync_clr |=> res == 48'h0 && !res_valid && !pd_valid)
        else $error("synchronous clear left state");

    c_accumulate: cover property (
        res_valid && $past(chk_acc, 3) ##1 res_valid);
    c_simd_quad: cover property (res_valid && $past(chk_simd, 3));
    c_count: cover property (res_valid && $past(chk_up, 3));
    c_pattern: cover property (pd_valid && pat_match);

endmodule // dms_slice

// ---- bench/dms_fabric.sv ----
// fabric-side model: hands operands and controls to the slice
// assumes the bench raises req for one cycle per item
`timescale 1ns/10ps

module dms_fabric (
    input wire logic core_clk,
    input wire logic req,
    input wire dms_pkg::dms_opnd_s req_opnd,
    input wire dms_pkg::dms_ctl_s req_ctl,
    output logic in_valid,
    output dms_pkg::dms_opnd_s opnd,
    output dms_pkg::dms_ctl_s ctl
);
    // ========================================================
    // launch register
    initial in_valid = 1'b0;
    always @(posedge core_clk) begin
        in_valid <= req;
        // idle operands toggle so stale data never looks valid
        opnd <= req ? req_opnd : ~opnd;
        ctl <= req ? req_ctl : ctl;
    end
endmodule // dms_fabric

// ---- bench/test_dms_slice.sv ----
// self-checking bench for the arithmetic slice
// assumes dms_pkg and the fabric model are compiled first
`timescale 1ns/10ps

module test_dms_slice;
    // ========================================================
    // stimulus and observed signals
    logic core_clk = 1'b0;
    logic rst_b = 1'b0;
    logic sync_clr = 1'b0;
    logic req = 1'b0;
    logic in_valid;
    dms_pkg::dms_opnd_s r_opnd = '0; // item for the model
    dms_pkg::dms_ctl_s r_ctl = '0;
    dms_pkg::dms_opnd_s opnd;
    dms_pkg::dms_ctl_s ctl;
    logic [5:0] reg_addr = 6'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    logic [31:0] rd_d;
    logic [47:0] res;
    logic [3:0] carry;
    logic [7:0] xor_out;
    logic res_valid, pd_valid, pat_match, pat_match_b;
    int n_errors = 0;
    int n_tests = 0;
    int cyc = 0;
    always #5 core_clk = ~core_clk;

    dms_fabric part_u (.core_clk, .req, .req_opnd(r_opnd),
        .req_ctl(r_ctl), .in_valid, .opnd, .ctl);
    dms_slice dut_u (.core_clk, .rst_b, .sync_clr, .in_valid,
        .opnd, .ctl, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_rdata, .res, .res_valid, .carry, .xor_out,
        .pd_valid, .pat_match, .pat_match_b);

    // ========================================================
    // shared tasks
    task final_report;
        $display("checks %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task chk(input string nm, input logic [47:0] s, e);
        n_tests++;
        if (s !== e) begin
            n_errors++;
            $display("MISMATCH %s exp %h seen %h", nm, e, s);
        end
    endtask
    task wr(input logic [5:0] a, input logic [31:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask
    // read data stands only in the cycle after the strobe
    task rd(input logic [5:0] a);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1;
        rd_d = reg_rdata;
    endtask
    // one item through the pipe, bounded wait for the result
    task run(input logic [47:0] e);
        @(posedge core_clk);
        req <= 1'b1;
        @(posedge core_clk);
        req <= 1'b0;
        for (int i = 0; i < 8; i++) begin
            @(posedge core_clk);
            #1;
            if (res_valid === 1'b1) break;
        end
        chk("res_valid", res_valid, 48'h1);
        chk("res", res, e);
    endtask
    function automatic logic [47:0] lf(int k, logic [47:0] z, w);
        case (k)
            0: return z & w;
            1: return z | w;
            2: return z ^ w;
            3: return ~(z & w);
            4: return ~(z | w);
            5: return ~(z ^ w);
            6: return z & ~w;
            7: return z | ~w;
            8: return ~z & w;
            default: return ~z | w;
        endcase
    endfunction

    // ========================================================
    // scenarios
    task t_regs;
        rd(dms_pkg::DMS_CTRL_OFS);
        chk("ctrl", rd_d, 48'h3);
        rd(6'h3C);
        chk("unmapped", rd_d, 48'h0);
        $display("done regs");
    endtask
    task t_mult;
        r_ctl = '0;
        r_opnd = '0;
        r_ctl.use_mult = 1'b1;
        r_opnd.a = 27'h4000000;
        r_opnd.b = 18'h20000;
        run(48'h080000000000);
        // d - a reaches 28 bits: no truncation allowed
        r_ctl.preadd_en = 1'b1;
        r_ctl.preadd_sub = 1'b1;
        r_opnd.d = 27'h3FFFFFF;
        r_opnd.b = 18'h00002;
        run(48'h00000FFFFFFE);
        // d + a is negative here: the sign must reach bit 47
        r_ctl.preadd_sub = 1'b0;
        run(48'hFFFFFFFFFFFE);
        $display("done mult");
    endtask
    task t_acc;
        r_ctl = '0;
        r_opnd = '0;
        r_opnd.ab = 48'h10;
        run(48'h10);
        r_ctl.zsel = dms_pkg::Z_ACC;
        run(48'h20);
        r_ctl.op = dms_pkg::OP_SUB;
        r_opnd.ab = 48'h5;
        run(48'h1B);
        r_ctl.op = dms_pkg::OP_CNT_UP;
        run(48'h1C);
        r_ctl.op = dms_pkg::OP_CNT_DN;
        run(48'h1B);
        run(48'h1A);
        rd(dms_pkg::DMS_ACCLO_OFS);
        chk("acc_lo", rd_d, 48'h1A);
        $display("done acc");
    endtask
    task t_simd;
        r_ctl = '0;
        r_opnd = '0;
        r_ctl.zsel = dms_pkg::Z_C;
        r_ctl.simd = dms_pkg::S_FOUR12;
        r_opnd.c = 48'hFFF001FFF001;
        r_opnd.ab = 48'h001FFF001FFF;
        run(48'h0);
        chk("carry", carry, 48'hF);
        r_ctl.op = dms_pkg::OP_SUB;
        r_opnd.c = 48'h001000001000;
        r_opnd.ab = 48'h000001000001;
        run(48'h001FFF001FFF);
        chk("borrow", carry, 48'hA);
        r_ctl.op = dms_pkg::OP_ADD;
        r_ctl.simd = dms_pkg::S_TWO24;
        r_opnd.c = 48'hFFFFFFFFFFFF;
        r_opnd.ab = 48'h000001000001;
        run(48'h0);
        $display("done simd");
    endtask
    task t_logic;
        r_ctl = '0;
        r_ctl.op = dms_pkg::OP_LOGIC;
        r_ctl.zsel = dms_pkg::Z_C;
        r_opnd.c = 48'hF0F0FF001234;
        r_opnd.ab = 48'hCCCCF0F0ABCD;
        for (int k = 0; k < 10; k++) begin
            r_ctl.lfn = dms_pkg::dms_lfn_e'(k);
            run(lf(k, r_opnd.c, r_opnd.ab));
        end
        $display("done logic");
    endtask
    task t_xor;
        logic [7:0] xt [4];
        xt = '{8'h19, 8'h07, 8'h02, 8'h01};
        r_ctl = '0;
        r_ctl.zsel = dms_pkg::Z_C;
        r_opnd.c = 48'h1;
        r_opnd.ab = 48'h001000000001;
        for (int w = 0; w < 4; w++) begin
            wr(dms_pkg::DMS_CTRL_OFS, 32'(w));
            run(48'h001000000002);
            chk("xor", xor_out, xt[w]);
        end
        $display("done xor");
    endtask
    task t_pat;
        wr(dms_pkg::DMS_PATLO_OFS, 32'h0000001A);
        r_ctl = '0;
        r_opnd = '0;
        r_opnd.ab = 48'h1A;
        run(48'h1A);
        @(posedge core_clk);
        #1;
        chk("pd_valid", pd_valid, 48'h1);
        chk("match", pat_match, 48'h1);
        chk("match_b", pat_match_b, 48'h0);
        // full mask: every bit is a don't care
        wr(dms_pkg::DMS_MSKLO_OFS, 32'hFFFFFFFF);
        wr(dms_pkg::DMS_MSKHI_OFS, 32'h0000FFFF);
        r_opnd.ab = 48'h5;
        run(48'h5);
        @(posedge core_clk);
        #1;
        chk("mask_b", pat_match_b, 48'h1);
        $display("done pattern");
    endtask
    task t_clr;
        logic seen;
        seen = 1'b0;
        r_opnd.ab = 48'h77;
        @(posedge core_clk);
        req <= 1'b1;
        @(posedge core_clk);
        req <= 1'b0;
        @(posedge core_clk);
        sync_clr <= 1'b1;
        @(posedge core_clk);
        sync_clr <= 1'b0;
        repeat (6) begin
            @(posedge core_clk);
            #1;
            seen = seen | res_valid;
        end
        chk("killed", seen, 48'h0);
        chk("cleared", res, 48'h0);
        $display("done clear");
    endtask

    // ========================================================
    // main sequence and hang guard
    initial begin
        repeat (2) @(posedge core_clk);
        rst_b <= 1'b1;
        t_regs;
        t_mult;
        t_acc;
        t_simd;
        t_logic;
        t_xor;
        t_pat;
        t_clr;
        final_report;
    end
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            n_errors++;
            final_report;
        end
    end
endmodule // test_dms_slice
